// ---- rtl/pcp_pkg.sv ----
package pcp_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int         DATA_W       = 8;
    localparam int         ADDR_W       = 8;
    localparam int         CNT_W        = 8;
    localparam int         NUM_OUT      = 6;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] OFF_CMP0     = 8'h18;
    localparam logic [7:0] OFF_CMP1     = 8'h19;
    localparam logic [7:0] OFF_PERIOD   = 8'h1A;
    localparam logic [7:0] OFF_POLINV   = 8'h1B;
    localparam logic [7:0] OFF_MODE     = 8'h1C;
    localparam logic [7:0] OFF_OVR_EN   = 8'h1D;
    localparam logic [7:0] OFF_OVR_VAL  = 8'h1E;
    localparam logic [7:0] OFF_COUNT    = 8'h1F;
    localparam logic [7:0] OFF_ENA      = 8'h20;

    // ****************************************
    // Enable control field positions
    // ****************************************
    localparam int         ENA_GEN_BIT  = 7;
    localparam int         ENA_GSEL_BIT = 6;
    localparam int         ENA_RSTR_BIT = 2;
    localparam int         ENA_LOK_BIT  = 1;

    // ****************************************
    // Mode register field positions
    // ****************************************
    localparam int         MODE_MTG_BIT = 0;
    localparam int         MODE_WP_BIT  = 1;
    localparam int         MODE_GENB_BIT = 2;
    localparam int         MODE_GENC_BIT = 3;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] ENA_RST      = 8'h00;
    localparam logic [7:0] CMP_RST      = 8'h00;
    localparam logic [7:0] PERIOD_RST   = 8'hFF;
    localparam logic [7:0] POLINV_RST   = 8'h00;
    localparam logic [7:0] MODE_RST     = 8'h00;
    localparam logic [7:0] OVR_RST      = 8'h00;

endpackage

// ---- rtl/pcp_cmp_if.sv ----
`timescale 1ns/100ps
interface pcp_cmp_if #(parameter int W = 8);
    logic [W-1:0]      cnt;
    logic [1:0][W-1:0] val;
    logic [1:0]        inv;
    logic [1:0]        hit;
    modport gen (output cnt, output val, output inv, input hit);
    modport cmp (input cnt, input val, input inv, output hit);
endinterface

// ---- rtl/pcp_compare.sv ----
`timescale 1ns/100ps
module pcp_compare #(
    parameter int W = 8
) (
    // Counter, compare values and polarity in, compare results out
    pcp_cmp_if.cmp cif
);

    // ****************************************
    // Per-output compare with polarity select
    // ****************************************
    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_cmp
            wire below;
            wire above;
            assign below      = cif.cnt < cif.val[i];
            assign above      = cif.cnt > cif.val[i];
            assign cif.hit[i] = cif.inv[i] ? above : below;
        end
    endgenerate

endmodule

// ---- rtl/pcp_top.sv ----
// Summary of operation
// - Polarity 0 picks below or above compare 0
// - Polarity 1 picks below or above compare 1
// - Polarity change acts at once, not deferred
// - Single mode: enable drives generators A-C, outputs 0-5
// - Disabled outputs inactive unless override set
// - Multi mode: enable drives generator A, outputs 0-1
// - Enabling forces reload at cycle start
// - Select chooses local or global load-OK
// - Restart bit lets commutation restart generator A
// - Write protect freezes select and restart bits
`timescale 1ns/100ps
module pcp_top #(
    parameter int CNT_W = pcp_pkg::CNT_W
) (
    // Clock and reset
    input  wire logic                      mclk,
    input  wire logic                      srst,
    // Register port
    input  wire logic [pcp_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [pcp_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output logic      [pcp_pkg::DATA_W-1:0] reg_rdata,
    // Device-level events
    input  wire logic                      global_load_ok,
    input  wire logic                      commutation_evt,
    // Raw waveforms of generators B and C for outputs 2 to 5
    input  wire logic [3:0]                pwm_raw_bc,
    // PWM outputs and generator state
    output logic      [5:0]                pwm_out,
    output logic                           gen_a_run,
    output logic                           gen_b_run,
    output logic                           gen_c_run,
    output logic                           reload_evt
);

    // ****************************************
    // Address decode
    // ****************************************
    function automatic logic sel(input logic [7:0] a, input logic [7:0] off);
        sel = (a == off);
    endfunction

    wire wr_ena    = reg_wr && sel(reg_addr, pcp_pkg::OFF_ENA);
    wire wr_cmp0   = reg_wr && sel(reg_addr, pcp_pkg::OFF_CMP0);
    wire wr_cmp1   = reg_wr && sel(reg_addr, pcp_pkg::OFF_CMP1);
    wire wr_period = reg_wr && sel(reg_addr, pcp_pkg::OFF_PERIOD);
    wire wr_polinv = reg_wr && sel(reg_addr, pcp_pkg::OFF_POLINV);
    wire wr_mode   = reg_wr && sel(reg_addr, pcp_pkg::OFF_MODE);
    wire wr_ovr_en = reg_wr && sel(reg_addr, pcp_pkg::OFF_OVR_EN);
    wire wr_ovr_v  = reg_wr && sel(reg_addr, pcp_pkg::OFF_OVR_VAL);

    // ****************************************
    // State
    // ****************************************
    logic             gen_en_r;
    logic             gsel_r;
    logic             rstr_r;
    logic             lok_r;
    logic             gpend_r;
    logic             run_q_r;
    logic [7:0]       mode_r;
    logic [1:0]       polinv_r;
    logic [5:0]       ovr_en_r;
    logic [5:0]       ovr_val_r;
    logic [CNT_W-1:0] cmp0_sh_r;
    logic [CNT_W-1:0] cmp1_sh_r;
    logic [CNT_W-1:0] period_sh_r;
    logic [CNT_W-1:0] cmp0_r;
    logic [CNT_W-1:0] cmp1_r;
    logic [CNT_W-1:0] period_r;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic [5:0]       pwm_nxt;
    logic [7:0]       rd_mux;

    wire multi_generator_mode       = mode_r[pcp_pkg::MODE_MTG_BIT];
    wire wp        = mode_r[pcp_pkg::MODE_WP_BIT];
    wire run       = gen_en_r;
    wire cyc_start = run && (cnt_r == '0);
    wire first     = run && !run_q_r;
    wire load_ok   = gsel_r ? gpend_r : lok_r;
    wire reload    = cyc_start && (first || load_ok);
    wire restart   = run && rstr_r && commutation_evt;

    // ****************************************
    // Enable control register
    // ****************************************
    always_ff @(posedge mclk) begin
        if (srst) begin
            gen_en_r <= pcp_pkg::ENA_RST[pcp_pkg::ENA_GEN_BIT];
            gsel_r   <= pcp_pkg::ENA_RST[pcp_pkg::ENA_GSEL_BIT];
            rstr_r   <= pcp_pkg::ENA_RST[pcp_pkg::ENA_RSTR_BIT];
        end else if (wr_ena) begin
            gen_en_r <= reg_wdata[pcp_pkg::ENA_GEN_BIT];
            if (!wp) begin
                gsel_r <= reg_wdata[pcp_pkg::ENA_GSEL_BIT];
                rstr_r <= reg_wdata[pcp_pkg::ENA_RSTR_BIT];
            end
        end
    end

    // Local load-OK: written as one, consumed by a reload, set wins
    always_ff @(posedge mclk) begin
        if (srst) begin
            lok_r <= pcp_pkg::ENA_RST[pcp_pkg::ENA_LOK_BIT];
        end else if (wr_ena && reg_wdata[pcp_pkg::ENA_LOK_BIT]) begin
            lok_r <= 1'b1;
        end else if (reload && !gsel_r) begin
            lok_r <= 1'b0;
        end
    end

    // Global load-OK pulse held until a reload takes it
    always_ff @(posedge mclk) begin
        if (srst) begin
            gpend_r <= 1'b0;
        end else if (global_load_ok) begin
            gpend_r <= 1'b1;
        end else if (reload && gsel_r) begin
            gpend_r <= 1'b0;
        end
    end

    // ****************************************
    // Other software registers
    // ****************************************
    always_ff @(posedge mclk) begin
        if (srst) begin
            mode_r      <= pcp_pkg::MODE_RST;
            polinv_r    <= pcp_pkg::POLINV_RST[1:0];
            ovr_en_r    <= pcp_pkg::OVR_RST[5:0];
            ovr_val_r   <= pcp_pkg::OVR_RST[5:0];
            cmp0_sh_r   <= CNT_W'(pcp_pkg::CMP_RST);
            cmp1_sh_r   <= CNT_W'(pcp_pkg::CMP_RST);
            period_sh_r <= CNT_W'(pcp_pkg::PERIOD_RST);
        end else begin
            if (wr_mode)   mode_r      <= {4'h0, reg_wdata[3:0]};
            if (wr_polinv) polinv_r    <= reg_wdata[1:0];
            if (wr_ovr_en) ovr_en_r    <= reg_wdata[5:0];
            if (wr_ovr_v)  ovr_val_r   <= reg_wdata[5:0];
            if (wr_cmp0)   cmp0_sh_r   <= CNT_W'(reg_wdata);
            if (wr_cmp1)   cmp1_sh_r   <= CNT_W'(reg_wdata);
            if (wr_period) period_sh_r <= CNT_W'(reg_wdata);
        end
    end

    // ****************************************
    // Double-buffered working values
    // ****************************************
    always_ff @(posedge mclk) begin
        if (srst) begin
            cmp0_r   <= CNT_W'(pcp_pkg::CMP_RST);
            cmp1_r   <= CNT_W'(pcp_pkg::CMP_RST);
            period_r <= CNT_W'(pcp_pkg::PERIOD_RST);
        end else if (reload) begin
            cmp0_r   <= cmp0_sh_r;
            cmp1_r   <= cmp1_sh_r;
            period_r <= period_sh_r;
        end
    end

    // ****************************************
    // Generator A counter
    // ****************************************
    always_comb begin
        if (!run) begin
            cnt_nxt = '0;
        end else if (restart) begin
            cnt_nxt = '0;
        end else if (cnt_r >= period_r) begin
            cnt_nxt = '0;
        end else begin
            cnt_nxt = cnt_r + CNT_W'(1);
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            cnt_r   <= '0;
            run_q_r <= 1'b0;
        end else begin
            cnt_r   <= cnt_nxt;
            run_q_r <= run;
        end
    end

    // ****************************************
    // Compare stage
    // ****************************************
    pcp_cmp_if #(.W(CNT_W)) cif ();

    assign cif.cnt    = cnt_r;
    assign cif.val[0] = cmp0_r;
    assign cif.val[1] = cmp1_r;
    assign cif.inv    = polinv_r;

    pcp_compare #(.W(CNT_W)) u_cmp (
        .cif (cif.cmp)
    );

    // ****************************************
    // Output enables and gating
    // ****************************************
    wire run_b = multi_generator_mode ? mode_r[pcp_pkg::MODE_GENB_BIT] : run;
    wire run_c = multi_generator_mode ? mode_r[pcp_pkg::MODE_GENC_BIT] : run;
    wire [5:0] out_en  = {run_c, run_c, run_b, run_b, run, run};
    wire [5:0] out_raw = {pwm_raw_bc, cif.hit};

    genvar k;
    generate
        for (k = 0; k < 6; k++) begin : g_out
            assign pwm_nxt[k] = ovr_en_r[k] ? ovr_val_r[k]
                                            : (out_en[k] && out_raw[k]);
        end
    endgenerate

    always_ff @(posedge mclk) begin
        if (srst) begin
            pwm_out    <= '0;
            reload_evt <= 1'b0;
        end else begin
            pwm_out    <= pwm_nxt;
            reload_evt <= reload;
        end
    end

    assign gen_a_run = run;
    assign gen_b_run = run_b;
    assign gen_c_run = run_c;

    // ****************************************
    // Read path
    // ****************************************
    always_comb begin
        case (reg_addr)
            pcp_pkg::OFF_ENA:     rd_mux = {gen_en_r, gsel_r, 3'h0, rstr_r, lok_r, 1'b0};
            pcp_pkg::OFF_CMP0:    rd_mux = 8'(cmp0_sh_r);
            pcp_pkg::OFF_CMP1:    rd_mux = 8'(cmp1_sh_r);
            pcp_pkg::OFF_PERIOD:  rd_mux = 8'(period_sh_r);
            pcp_pkg::OFF_POLINV:  rd_mux = {6'h00, polinv_r};
            pcp_pkg::OFF_MODE:    rd_mux = mode_r;
            pcp_pkg::OFF_OVR_EN:  rd_mux = {2'h0, ovr_en_r};
            pcp_pkg::OFF_OVR_VAL: rd_mux = {2'h0, ovr_val_r};
            pcp_pkg::OFF_COUNT:   rd_mux = 8'(cnt_r);
            default:              rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    sequence s_enable_on;
        !run_q_r && run;
    endsequence

    sequence s_comm_restart;
        run && rstr_r && commutation_evt;
    endsequence

    a_pol0_normal: assert property (@(posedge mclk) disable iff (srst)
        (run && !ovr_en_r[0] && !polinv_r[0]) |=> (pwm_out[0] == $past(cnt_r < cmp0_r)))
        else $error("output 0 wrong in normal polarity");

    a_pol0_invert: assert property (@(posedge mclk) disable iff (srst)
        (run && !ovr_en_r[0] && polinv_r[0]) |=> (pwm_out[0] == $past(cnt_r > cmp0_r)))
        else $error("output 0 wrong in inverted polarity");

    a_pol1_both: assert property (@(posedge mclk) disable iff (srst)
        (run && !ovr_en_r[1]) |=>
        (pwm_out[1] == ($past(polinv_r[1]) ? $past(cnt_r > cmp1_r) : $past(cnt_r < cmp1_r))))
        else $error("output 1 wrong for its polarity");

    a_pol_immediate: assert property (@(posedge mclk) disable iff (srst)
        (wr_polinv && reg_wdata[0] && run && !ovr_en_r[0] && cmp0_r == '0 && cnt_nxt != '0
         && !$changed(cmp0_r)) |=> ##1 pwm_out[0])
        else $error("polarity change not applied at once");

    a_single_mode: assert property (@(posedge mclk) disable iff (srst)
        (!multi_generator_mode && !ovr_en_r[4]) |=> (pwm_out[4] == $past(run && pwm_raw_bc[2])))
        else $error("output 4 not tied to generator A enable");

    a_disabled_low: assert property (@(posedge mclk) disable iff (srst)
        (!run && !multi_generator_mode && (ovr_en_r == 6'h00)) |=> (pwm_out == 6'h00))
        else $error("disabled outputs not inactive");

    a_multi_mode: assert property (@(posedge mclk) disable iff (srst)
        (multi_generator_mode && !mode_r[pcp_pkg::MODE_GENB_BIT] && !ovr_en_r[2]) |=> !pwm_out[2])
        else $error("generator A enable leaked to output 2");

    a_enable_reload: assert property (@(posedge mclk) disable iff (srst)
        s_enable_on |=> reload_evt)
        else $error("no reload after enable");

    a_global_gate: assert property (@(posedge mclk) disable iff (srst)
        (cyc_start && !first && gsel_r && !gpend_r) |=> !reload_evt)
        else $error("reload without global load-OK");

    a_local_gate: assert property (@(posedge mclk) disable iff (srst)
        (cyc_start && !gsel_r && lok_r) |=> (reload_evt && (!lok_r || $past(wr_ena))))
        else $error("local load-OK did not reload");

    a_comm_restart: assert property (@(posedge mclk) disable iff (srst)
        s_comm_restart |=> (cnt_r == '0))
        else $error("commutation did not restart counter");

    a_no_restart: assert property (@(posedge mclk) disable iff (srst)
        (run && !rstr_r && commutation_evt && cnt_r < period_r && gen_en_r && !wr_ena)
        |=> (cnt_r == $past(cnt_r) + CNT_W'(1)))
        else $error("counter restarted with restart bit clear");

    a_write_protect: assert property (@(posedge mclk) disable iff (srst)
        (wp && wr_ena) |=> ($stable(gsel_r) && $stable(rstr_r)))
        else $error("protected bits changed");

    a_unused_zero: assert property (@(posedge mclk) disable iff (srst)
        (reg_rd && reg_addr == pcp_pkg::OFF_ENA) |=> (reg_rdata[5:3] == 3'h0 && !reg_rdata[0]))
        else $error("unused enable bits not zero");

endmodule

// ---- verification/pcp_gate_drv_model.sv ----
`timescale 1ns/100ps
module pcp_gate_drv_model (
    // Clock
    input  wire logic       mclk,
    // Gate commands and measurement window
    input  wire logic [5:0] pwm_out,
    input  wire logic       win,
    // On-time of the two phase-A gates inside the window
    output logic      [7:0] on_cnt0,
    output logic      [7:0] on_cnt1
);
    // Gate stage only integrates on-time while the window is open
    always_ff @(posedge mclk) begin
        if (!win) begin
            on_cnt0 <= 8'h00;
            on_cnt1 <= 8'h00;
        end else begin
            on_cnt0 <= on_cnt0 + {7'h00, pwm_out[0]};
            on_cnt1 <= on_cnt1 + {7'h00, pwm_out[1]};
        end
    end
endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
    logic       mclk            = 1'b0;
    logic       srst            = 1'b1;
    logic [7:0] reg_addr        = 8'h00;
    logic [7:0] reg_wdata       = 8'h00;
    logic       reg_wr          = 1'b0;
    logic       reg_rd          = 1'b0;
    logic [7:0] reg_rdata;
    logic       global_load_ok  = 1'b0;
    logic       commutation_evt = 1'b0;
    logic [3:0] pwm_raw_bc      = 4'h0;
    logic [5:0] pwm_out;
    logic       gen_a_run;
    logic       gen_b_run;
    logic       gen_c_run;
    logic       reload_evt;
    logic       win             = 1'b0;
    logic [7:0] on_cnt0;
    logic [7:0] on_cnt1;
    int         fail_count      = 0;
    int         num_checks      = 0;
    int         reload_cnt      = 0;
    int         cyc             = 0;

    always #2.5 mclk = ~mclk;

    pcp_top #(.CNT_W(pcp_pkg::CNT_W)) u_dut (
        .mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .global_load_ok(global_load_ok), .commutation_evt(commutation_evt),
        .pwm_raw_bc(pwm_raw_bc), .pwm_out(pwm_out), .gen_a_run(gen_a_run),
        .gen_b_run(gen_b_run), .gen_c_run(gen_c_run), .reload_evt(reload_evt)
    );

    pcp_gate_drv_model u_drv (
        .mclk(mclk), .pwm_out(pwm_out), .win(win), .on_cnt0(on_cnt0), .on_cnt1(on_cnt1)
    );

    // ****************************************
    // Common tasks
    // ****************************************
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc++;
        if (reload_evt === 1'b1)
            reload_cnt++;
        if (cyc == 20000) begin
            fail_count++;
            complete_run();
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        check(d, exp);
    endtask

    // Period 9 gives ten counts per cycle, so a ten-cycle window is one full cycle
    task automatic duty(input logic [7:0] e0, input logic [7:0] e1);
        repeat (2) @(posedge mclk);
        win <= 1'b1;
        repeat (10) @(posedge mclk);
        win <= 1'b0;
        #1;
        check(on_cnt0, e0);
        check(on_cnt1, e1);
    endtask

    task automatic reloads_since(input int n, input int waitc, input logic exp);
        repeat (waitc) @(posedge mclk);
        check({7'h00, reload_cnt != n}, {7'h00, exp});
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        rd_chk(pcp_pkg::OFF_ENA, 8'h00);
        rd_chk(8'h40, 8'h00);
        check({2'b00, pwm_out}, 8'h00);
    endtask

    task automatic t_protect();
        wr(pcp_pkg::OFF_ENA, 8'h7D);
        rd_chk(pcp_pkg::OFF_ENA, 8'h44);
        wr(pcp_pkg::OFF_MODE, 8'h02);
        wr(pcp_pkg::OFF_ENA, 8'h80);
        rd_chk(pcp_pkg::OFF_ENA, 8'hC4);
        wr(pcp_pkg::OFF_ENA, 8'h00);
        rd_chk(pcp_pkg::OFF_ENA, 8'h44);
        wr(pcp_pkg::OFF_MODE, 8'h00);
        wr(pcp_pkg::OFF_ENA, 8'h00);
        rd_chk(pcp_pkg::OFF_ENA, 8'h00);
    endtask

    task automatic t_duty();
        int n;
        wr(pcp_pkg::OFF_PERIOD, 8'h09);
        wr(pcp_pkg::OFF_CMP0, 8'h03);
        wr(pcp_pkg::OFF_CMP1, 8'h07);
        n = reload_cnt;
        wr(pcp_pkg::OFF_ENA, 8'h80);
        reloads_since(n, 14, 1'b1);
        check({7'h00, gen_a_run}, 8'h01);
        duty(8'h03, 8'h07);
        wr(pcp_pkg::OFF_POLINV, 8'h03);
        duty(8'h06, 8'h02);
    endtask

    task automatic t_group();
        // Pin outputs 0 and 1 high by override so the whole output word is fixed
        wr(pcp_pkg::OFF_OVR_VAL, 8'h03);
        wr(pcp_pkg::OFF_OVR_EN, 8'h03);
        @(posedge mclk);
        pwm_raw_bc <= 4'hF;
        repeat (3) @(posedge mclk);
        check({gen_b_run, gen_c_run, pwm_out}, 8'hFF);
        wr(pcp_pkg::OFF_MODE, 8'h01);
        repeat (3) @(posedge mclk);
        check({gen_b_run, gen_c_run, 2'b00, pwm_out[5:2]}, 8'h00);
        wr(pcp_pkg::OFF_MODE, 8'h05);
        repeat (3) @(posedge mclk);
        check({gen_b_run, gen_c_run, 2'b00, pwm_out[5:2]}, 8'h83);
        wr(pcp_pkg::OFF_MODE, 8'h09);
        repeat (3) @(posedge mclk);
        check({gen_b_run, gen_c_run, 2'b00, pwm_out[5:2]}, 8'h4C);
        wr(pcp_pkg::OFF_MODE, 8'h00);
        wr(pcp_pkg::OFF_OVR_EN, 8'h00);
    endtask

    task automatic t_load();
        int n;
        wr(pcp_pkg::OFF_CMP0, 8'h00);
        n = reload_cnt;
        wr(pcp_pkg::OFF_ENA, 8'hC2);
        reloads_since(n, 24, 1'b0);
        @(posedge mclk);
        global_load_ok <= 1'b1;
        @(posedge mclk);
        global_load_ok <= 1'b0;
        reloads_since(n, 14, 1'b1);
        wr(pcp_pkg::OFF_ENA, 8'h80);
        wr(pcp_pkg::OFF_POLINV, 8'h00);
        duty(8'h00, 8'h07);
        wr(pcp_pkg::OFF_POLINV, 8'h01);
        duty(8'h09, 8'h07);
    endtask

    // Synchronise on a reload, then commutate a few counts later and read the counter
    task automatic restart_case(input logic [7:0] ena, input logic exp_low);
        int         n;
        logic [7:0] d;
        n = reload_cnt;
        wr(pcp_pkg::OFF_ENA, ena);
        for (int i = 0; i < 80 && reload_cnt == n; i++) begin
            @(posedge mclk);
            #1;
        end
        @(posedge mclk);
        commutation_evt <= 1'b1;
        @(posedge mclk);
        commutation_evt <= 1'b0;
        rd(pcp_pkg::OFF_COUNT, d);
        check({7'h00, d < 8'h04}, {7'h00, exp_low});
    endtask

    task automatic t_restart();
        wr(pcp_pkg::OFF_PERIOD, 8'h3F);
        restart_case(8'h82, 1'b0);
        restart_case(8'h86, 1'b1);
    endtask

    task automatic t_disable();
        wr(pcp_pkg::OFF_ENA, 8'h00);
        wr(pcp_pkg::OFF_OVR_EN, 8'h03);
        wr(pcp_pkg::OFF_OVR_VAL, 8'h01);
        repeat (3) @(posedge mclk);
        check({gen_a_run, gen_b_run, pwm_out}, 8'h01);
    endtask

    initial begin
        repeat (5) @(posedge mclk);
        srst <= 1'b0;
        t_reset();
        t_protect();
        t_duty();
        t_group();
        t_load();
        t_restart();
        t_disable();
        complete_run();
    end
endmodule
